// *** design/cgr_pkg.sv ***
package cgr_pkg;

  // Global register indices, plus the device activate index
  localparam logic [7:0] IDX_CFG_CTRL    = 8'h02;
  localparam logic [7:0] IDX_LDEV_SEL    = 8'h07;
  localparam logic [7:0] IDX_DEV_ID      = 8'h20;
  localparam logic [7:0] IDX_DEV_REV     = 8'h21;
  localparam logic [7:0] IDX_PWR         = 8'h22;
  localparam logic [7:0] IDX_RSV         = 8'h23;
  localparam logic [7:0] IDX_OSC         = 8'h24;
  localparam logic [7:0] IDX_ADDR_LO     = 8'h26;
  localparam logic [7:0] IDX_ADDR_HI     = 8'h27;
  localparam logic [7:0] IDX_GLOBAL_LAST = 8'h2F;
  localparam logic [7:0] IDX_ACTIVATE    = 8'h30;

  // Field positions
  localparam int SOFT_RST_BIT    = 0;
  localparam int PWR_FDC_BIT     = 0;
  localparam int PWR_PAR_BIT     = 3;
  localparam int PWR_SER1_BIT    = 4;
  localparam int PWR_SER2_BIT    = 5;
  localparam int OSC_PLL_OFF_BIT = 1;
  localparam int OSC_CLK_LSB     = 2;
  localparam int OSC_ADDR16_BIT  = 6;
  localparam int ACTIVATE_BIT    = 0;

  // Writable bit masks; other bits read zero
  localparam logic [7:0] PWR_WR_MASK     = 8'h39;
  localparam logic [7:0] OSC_WR_MASK     = 8'h4E;
  localparam logic [7:0] ADDR_LO_MASK    = 8'hFE;
  localparam logic [1:0] OSC_STOP_CODE   = 2'h3;

  // Values after reset
  localparam logic [7:0]  LDEV_RST       = 8'h00;
  localparam logic [7:0]  PWR_RST        = 8'h00;
  localparam logic [7:0]  RSV_RST        = 8'h00;
  localparam logic [7:0]  OSC_RST        = 8'h44;
  localparam logic [7:0]  IDX_RST        = 8'h00;
  localparam logic [15:0] ADDR_BOOT_RST  = 16'h002E;

  // Strap-selected configuration port addresses
  localparam logic [15:0] ADDR_STRAP_00  = 16'h162E;
  localparam logic [15:0] ADDR_STRAP_01  = 16'h164E;
  localparam logic [15:0] ADDR_STRAP_10  = 16'h002E;
  localparam logic [15:0] ADDR_STRAP_11  = 16'h004E;

  // Port qualification
  localparam logic [15:0] QUAL12_MASK    = 16'h0FFF;
  localparam logic [15:0] QUAL16_MASK    = 16'hFFFF;
  localparam logic [15:0] DATA_PORT_OFS  = 16'h0001;

endpackage

// *** design/cgr_port_dec.sv ***
`timescale 1ns/1ps
`default_nettype none
module cgr_port_dec
  import cgr_pkg::*;
(
  // Host cycle address
  input  wire logic [15:0] addr_in,
  // Current configuration port base and qualification width
  input  wire logic [15:0] base_in,
  input  wire logic        qual16_in,
  // Port hits
  output logic             idx_hit_out,
  output logic             dat_hit_out
);

  // Compare only the qualified address bits
  function automatic logic port_match(input logic [15:0] addr,
                                      input logic [15:0] port,
                                      input logic        q16);
    logic [15:0] mask;
    mask = q16 ? QUAL16_MASK : QUAL12_MASK;
    return ((addr ^ port) & mask) == 16'h0000;
  endfunction

  logic [15:0] data_port;  // Data port sits one above index port

  assign data_port   = 16'(base_in + DATA_PORT_OFS);
  assign idx_hit_out = port_match(addr_in, base_in, qual16_in);   // [RL15]
  assign dat_hit_out = port_match(addr_in, data_port, qual16_in); // [RL15]

endmodule
`default_nettype wire

// *** design/cgr_rst_ctl.sv ***
`timescale 1ns/1ps
`default_nettype none
module cgr_rst_ctl
  import cgr_pkg::*;
(
  // Clock and main power-on reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Other reset sources
  input  wire logic        bus_rst_in,
  input  wire logic        standby_por_in,
  input  wire logic        soft_req_in,
  // Strap
  input  wire logic [1:0]  sysopt_in,
  // Reset controls to the bank
  output logic             hard_clr_out,
  output logic             soft_pulse_out,
  output logic             addr_load_out,
  output logic [15:0]      strap_addr_out
);

  logic boot_done_reg;  // Low until first cycle after release
  logic soft_reg;       // Self-clearing soft reset

  // Strap cannot be sampled under async reset, so load after release
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      boot_done_reg <= 1'b0;
    end else begin
      boot_done_reg <= 1'b1;
    end
  end

  // Soft reset lasts one cycle and clears itself
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      soft_reg <= 1'b0;
    end else begin
      soft_reg <= soft_req_in;  // [RL6]
    end
  end

  // Strap decode to configuration port default
  always_comb begin
    case (sysopt_in)
      2'h0:    strap_addr_out = ADDR_STRAP_00;  // [RL22]
      2'h1:    strap_addr_out = ADDR_STRAP_01;  // [RL22]
      2'h2:    strap_addr_out = ADDR_STRAP_10;  // [RL22]
      default: strap_addr_out = ADDR_STRAP_11;  // [RL22]
    endcase
  end

  assign hard_clr_out   = bus_rst_in | standby_por_in;
  assign soft_pulse_out = soft_reg;
  // Address reload only on bus reset or main power-on
  assign addr_load_out  = !boot_done_reg | bus_rst_in;  // [RL21]

endmodule
`default_nettype wire

// *** design/cgr_bank.sv ***
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RL1] Global registers occupy indices 0x00 to 0x2F
// [RL2] Index port decodes all eight bits
// [RL3] Unimplemented indices and bits read zero
// [RL4] Data port reaches the currently indexed register
// [RL5] Ports respond only in configuration mode
// [RL6] Bit0 of 0x02 fires self-clearing soft reset
// [RL7] Selector at 0x07 picks logical device bank
// [RL8] Activate write touches selected device only
// [RL9] Index 0x20 returns fixed device code
// [RL10] Index 0x21 returns fixed revision, read-only
// [RL11] Power enables for floppy, parallel, two serials
// [RL12] Host should not write index 0x23
// [RL13] Oscillator bit1 set turns PLL off
// [RL14] Clock code 11 stops oscillator, baud clock
// [RL15] Bit6 picks 12 or 16 bit qualification
// [RL16] Host should set 16-bit qualification
// [RL17] Oscillator register resets to 0x44
// [RL18] Address byte 0 holds bits 7:1, even
// [RL19] Address byte 1 holds bits 15:8
// [RL20] Port moves when address byte 1 written
// [RL21] Port address reset only by bus, main POR
// [RL22] Strap picks one of four default addresses
module cgr_bank
  import cgr_pkg::*;
#(
  parameter int         NUM_LDEV    = 16,
  parameter logic [7:0] DEV_ID_VAL  = 8'hA5,  // Arbitrary value
  parameter logic [7:0] DEV_REV_VAL = 8'h01   // Arbitrary value
)(
  // Clock and main power-on reset
  input  wire logic                clk_in,
  input  wire logic                rst_b_in,
  // Other reset sources and strap
  input  wire logic                bus_rst_in,
  input  wire logic                standby_por_in,
  input  wire logic [1:0]          sysopt_in,
  // Configuration mode from entry logic
  input  wire logic                cfg_mode_in,
  // Host I/O cycles
  input  wire logic [15:0]         io_addr_in,
  input  wire logic                io_wr_in,
  input  wire logic                io_rd_in,
  input  wire logic [7:0]          io_wdata_in,
  output logic [7:0]               io_rdata_out,
  output logic                     io_rdata_valid_out,
  // Logical device control
  output logic [7:0]               ldev_select_out,
  output logic [NUM_LDEV-1:0]      ldev_active_out,
  output logic                     soft_reset_out,
  // Power enables
  output logic                     floppy_ctrl_power_out,
  output logic                     par_port_power_out,
  output logic                     ser1_power_out,
  output logic                     ser2_power_out,
  // Clock and qualification control
  output logic                     pll_off_out,
  output logic                     osc_stop_out,
  output logic                     baud_rate_clock_en_out,
  output logic                     addr16_qual_out,
  // Current configuration port base
  output logic [15:0]              cfg_base_out
);

  localparam int LDEV_W = (NUM_LDEV > 1) ? $clog2(NUM_LDEV) : 1;

  logic [7:0]          idx_reg;       // Current index
  logic [7:0]          ldev_reg;      // Logical device selector
  logic [7:0]          pwr_reg;       // Power enables
  logic [7:0]          rsv_reg;       // Reserved read/write byte
  logic [7:0]          osc_reg;       // Oscillator control
  logic [7:0]          addr_lo_reg;   // Address byte 0
  logic [7:0]          addr_hi_reg;   // Address byte 1
  logic [15:0]         base_reg;      // Live port base
  logic [NUM_LDEV-1:0] active_reg;    // Activate bit per device
  logic                osc_stop_reg;  // Decoded stop
  logic                baud_en_reg;   // Decoded baud enable
  logic [7:0]          rdata_reg;     // Read answer
  logic                rvalid_reg;    // Read answer strobe
  logic [7:0]          rd_val;        // Data port read mux
  logic                idx_hit;
  logic                dat_hit;
  logic                wr_idx;
  logic                wr_dat;
  logic                rd_any;
  logic                hard_clr;
  logic                soft_pulse;
  logic                addr_load;
  logic [15:0]         strap_addr;
  logic                sel_ok;        // Selector names a real device
  logic [LDEV_W-1:0]   sel;

  // True when the data port write targets index i
  function automatic logic wr_to(input logic       wr,
                                 input logic [7:0] cur,
                                 input logic [7:0] i);
    return wr && (cur == i);
  endfunction

  cgr_port_dec u_dec (
    .addr_in     (io_addr_in),
    .base_in     (base_reg),
    .qual16_in   (osc_reg[OSC_ADDR16_BIT]),
    .idx_hit_out (idx_hit),
    .dat_hit_out (dat_hit)
  );

  cgr_rst_ctl u_rst (
    .clk_in         (clk_in),
    .rst_b_in       (rst_b_in),
    .bus_rst_in     (bus_rst_in),
    .standby_por_in (standby_por_in),
    .soft_req_in    (wr_to(wr_dat, idx_reg, IDX_CFG_CTRL)
                     && io_wdata_in[SOFT_RST_BIT]),  // [RL6]
    .sysopt_in      (sysopt_in),
    .hard_clr_out   (hard_clr),
    .soft_pulse_out (soft_pulse),
    .addr_load_out  (addr_load),
    .strap_addr_out (strap_addr)
  );

  // Accesses outside configuration mode are dropped
  assign wr_idx = cfg_mode_in && io_wr_in && idx_hit;  // [RL5]
  assign wr_dat = cfg_mode_in && io_wr_in && dat_hit;  // [RL5]
  assign rd_any = cfg_mode_in && io_rd_in && (idx_hit || dat_hit);
  assign sel_ok = ldev_reg < 8'(NUM_LDEV);
  assign sel    = ldev_reg[LDEV_W-1:0];

  // Index register keeps all eight bits, no aliasing
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idx_reg <= IDX_RST;
    end else if (wr_idx) begin
      idx_reg <= io_wdata_in;  // [RL2] [RL4]
    end
  end

  // Logical device selector, cleared by every reset
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ldev_reg <= LDEV_RST;
    end else if (hard_clr || soft_pulse) begin
      ldev_reg <= LDEV_RST;
    end else if (wr_to(wr_dat, idx_reg, IDX_LDEV_SEL)) begin
      ldev_reg <= io_wdata_in;  // [RL7]
    end
  end

  // Power enables, reserved bits never stored
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwr_reg <= PWR_RST;
    end else if (hard_clr || soft_pulse) begin
      pwr_reg <= PWR_RST;
    end else if (wr_to(wr_dat, idx_reg, IDX_PWR)) begin
      pwr_reg <= io_wdata_in & PWR_WR_MASK;  // [RL11] [RL3]
    end
  end

  // Reserved byte stores anything; soft reset leaves it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rsv_reg <= RSV_RST;
    end else if (hard_clr) begin
      rsv_reg <= RSV_RST;
    end else if (wr_to(wr_dat, idx_reg, IDX_RSV)) begin
      rsv_reg <= io_wdata_in;
    end
  end

  // Oscillator control; soft reset leaves it
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_reg <= OSC_RST;  // [RL17]
    end else if (hard_clr) begin
      osc_reg <= OSC_RST;  // [RL17]
    end else if (wr_to(wr_dat, idx_reg, IDX_OSC)) begin
      osc_reg <= io_wdata_in & OSC_WR_MASK;  // [RL13] [RL15] [RL3]
    end
  end

  // Clock code decode, registered so outputs come from flops
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      osc_stop_reg <= 1'b0;
      baud_en_reg  <= 1'b1;
    end else begin
      osc_stop_reg <= osc_reg[OSC_CLK_LSB+:2] == OSC_STOP_CODE;  // [RL14]
      baud_en_reg  <= osc_reg[OSC_CLK_LSB+:2] != OSC_STOP_CODE;  // [RL14]
    end
  end

  // Address bytes; standby power-on and soft reset leave them
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      addr_lo_reg <= ADDR_BOOT_RST[7:0];
      addr_hi_reg <= ADDR_BOOT_RST[15:8];
    end else if (addr_load) begin
      addr_lo_reg <= strap_addr[7:0];   // [RL21] [RL22]
      addr_hi_reg <= strap_addr[15:8];  // [RL21] [RL22]
    end else if (wr_to(wr_dat, idx_reg, IDX_ADDR_LO)) begin
      addr_lo_reg <= io_wdata_in & ADDR_LO_MASK;  // [RL18]
    end else if (wr_to(wr_dat, idx_reg, IDX_ADDR_HI)) begin
      addr_hi_reg <= io_wdata_in;  // [RL19]
    end
  end

  // Live base moves only on the high byte, so a half-written
  // address never moves the port under the host
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      base_reg <= ADDR_BOOT_RST;
    end else if (addr_load) begin
      base_reg <= strap_addr;  // [RL21]
    end else if (wr_to(wr_dat, idx_reg, IDX_ADDR_HI)) begin
      base_reg <= {io_wdata_in, addr_lo_reg};  // [RL20]
    end
  end

  // One activate bit per logical device
  for (genvar d = 0; d < NUM_LDEV; d++) begin : g_act
    always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
        active_reg[d] <= 1'b0;
      end else if (hard_clr || soft_pulse) begin
        active_reg[d] <= 1'b0;
      end else if (wr_to(wr_dat, idx_reg, IDX_ACTIVATE) && sel_ok
                   && (sel == LDEV_W'(d))) begin
        active_reg[d] <= io_wdata_in[ACTIVATE_BIT];  // [RL8]
      end
    end
  end

  // Data port read mux; anything unlisted reads zero
  always_comb begin
    rd_val = 8'h00;  // [RL1] [RL3]
    if (idx_reg == IDX_LDEV_SEL) begin
      rd_val = ldev_reg;
    end else if (idx_reg == IDX_DEV_ID) begin
      rd_val = DEV_ID_VAL;  // [RL9]
    end else if (idx_reg == IDX_DEV_REV) begin
      rd_val = DEV_REV_VAL;  // [RL10]
    end else if (idx_reg == IDX_PWR) begin
      rd_val = pwr_reg;
    end else if (idx_reg == IDX_RSV) begin
      rd_val = rsv_reg;
    end else if (idx_reg == IDX_OSC) begin
      rd_val = osc_reg;
    end else if (idx_reg == IDX_ADDR_LO) begin
      rd_val = addr_lo_reg;
    end else if (idx_reg == IDX_ADDR_HI) begin
      rd_val = addr_hi_reg;
    end else if (idx_reg == IDX_ACTIVATE && sel_ok) begin
      rd_val = {7'h00, active_reg[sel]};
    end
  end

  // Read answer one cycle after the strobe, held until next read
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rd_any;  // [RL5]
      if (rd_any) begin
        rdata_reg <= idx_hit ? idx_reg : rd_val;  // [RL4]
      end
    end
  end

  assign io_rdata_out           = rdata_reg;
  assign io_rdata_valid_out     = rvalid_reg;
  assign ldev_select_out        = ldev_reg;
  assign ldev_active_out        = active_reg;
  assign soft_reset_out         = soft_pulse;
  assign floppy_ctrl_power_out  = pwr_reg[PWR_FDC_BIT];
  assign par_port_power_out     = pwr_reg[PWR_PAR_BIT];
  assign ser1_power_out         = pwr_reg[PWR_SER1_BIT];
  assign ser2_power_out         = pwr_reg[PWR_SER2_BIT];
  assign pll_off_out            = osc_reg[OSC_PLL_OFF_BIT];
  assign osc_stop_out           = osc_stop_reg;
  assign baud_rate_clock_en_out = baud_en_reg;
  assign addr16_qual_out        = osc_reg[OSC_ADDR16_BIT];
  assign cfg_base_out           = base_reg;

  // Checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_soft_write;
    wr_to(wr_dat, idx_reg, IDX_CFG_CTRL) && io_wdata_in[SOFT_RST_BIT];
  endsequence

  sequence s_osc_stop_write;
    wr_to(wr_dat, idx_reg, IDX_OSC) && !hard_clr
      && io_wdata_in[OSC_CLK_LSB+:2] == OSC_STOP_CODE;
  endsequence

  soft_pulse_a: assert property (s_soft_write |=> soft_reset_out
      ##1 (!soft_reset_out || $past(wr_dat)))  // [RL6]
    else $error("soft reset did not pulse once");

  soft_clear_a: assert property (soft_reset_out && !hard_clr
      |=> ldev_select_out == LDEV_RST && pwr_reg == PWR_RST)  // [RL6]
    else $error("soft reset did not clear selector and power");

  mode_gate_a: assert property (!cfg_mode_in |=> !io_rdata_valid_out)  // [RL5]
    else $error("read answered outside configuration mode");

  unimpl_zero_a: assert property (rd_any && dat_hit && !idx_hit
      && idx_reg > IDX_GLOBAL_LAST && idx_reg != IDX_ACTIVATE
      |=> io_rdata_valid_out && io_rdata_out == 8'h00)  // [RL3]
    else $error("unimplemented index read nonzero");

  id_read_a: assert property (rd_any && dat_hit && !idx_hit
      && idx_reg == IDX_DEV_ID |=> io_rdata_out == DEV_ID_VAL)  // [RL9]
    else $error("device code read wrong");

  base_move_a: assert property (wr_to(wr_dat, idx_reg, IDX_ADDR_HI)
      && !addr_load |=> cfg_base_out == {$past(io_wdata_in), addr_lo_reg})  // [RL20]
    else $error("port base did not move on high byte");

  lo_hold_a: assert property (wr_to(wr_dat, idx_reg, IDX_ADDR_LO)
      && !addr_load |=> $stable(cfg_base_out))  // [RL20]
    else $error("port base moved on low byte");

  even_base_a: assert property (cfg_base_out[0] == 1'b0)  // [RL18]
    else $error("port base odd");

  osc_stop_a: assert property (s_osc_stop_write
      |=> ##1 osc_stop_out && !baud_rate_clock_en_out)  // [RL14]
    else $error("oscillator stop code not applied");

  osc_reset_a: assert property (hard_clr |=> osc_reg == OSC_RST
      && (cfg_base_out == $past(cfg_base_out)
      || $past(bus_rst_in)))  // [RL17]
    else $error("oscillator reset value wrong");

  act_only_sel_a: assert property (wr_to(wr_dat, idx_reg, IDX_ACTIVATE)
      && !hard_clr && !soft_pulse |=> (($past(active_reg) ^ active_reg)
      & ~(NUM_LDEV'(1) << $past(sel))) == '0)  // [RL8]
    else $error("activate touched another device");

endmodule
`default_nettype wire

// *** sim/cgr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// Host model: drives the index and data ports off the falling edge
module cgr_host (
  // Clock
  input  wire logic        clk_in,
  // Host I/O cycle
  output var logic         cfg_mode_out,
  output var logic [15:0]  io_addr_out,
  output var logic         io_wr_out,
  output var logic         io_rd_out,
  output var logic [7:0]   io_wdata_out
);
  logic [15:0] base;     // Port address the host believes in
  logic [7:0]  exp_q[$]; // Expected read answers, oldest first

  // Quiet bus at time zero
  initial begin
    cfg_mode_out = 1'b1;
    io_addr_out = 16'h0000;
    io_wr_out = 1'b0;
    io_rd_out = 1'b0;
    io_wdata_out = 8'h00;
    base = 16'h002E;
  end

  // One strobe, held across the sampling edge; answer noted if due
  task automatic acc(input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic resp);
    @(negedge clk_in);
    io_addr_out = a;
    io_wr_out = w;
    io_rd_out = !w;
    io_wdata_out = d;
    if (!w && resp) begin
      exp_q.push_back(d);
    end
    @(posedge clk_in);
  endtask

  // Drop strobes; needed after the last of a burst
  task automatic idle;
    @(negedge clk_in);
    io_wr_out = 1'b0;
    io_rd_out = 1'b0;
  endtask

  // Index first, then data port; index 0x23 is never written
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    acc(1'b1, base, i, 1'b1);
    acc(1'b1, base + 16'h0001, d, 1'b1);
  endtask

  // Index write, then data read with its expected answer
  task automatic rreg(input logic [7:0] i, input logic [7:0] e);
    acc(1'b1, base, i, 1'b1);
    acc(1'b0, base + 16'h0001, e, 1'b1);
  endtask
endmodule
`default_nettype wire

// *** sim/cgr_bank_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the global register bank
module cgr_bank_test;
  import cgr_pkg::*;
  logic clk_in, rst_b_in, bus_rst_in, standby_por_in, cfg_mode;
  logic [1:0] sysopt_in;
  logic [15:0] io_addr, cfg_base_out, ldev_active_out;
  logic io_wr, io_rd, io_rdata_valid_out, soft_reset_out;
  logic [7:0] io_wdata, io_rdata_out, ldev_select_out;
  logic fpw, ppw, s1pw, s2pw, pll_off, osc_stop, brg_en, q16;
  int error_cnt, compares, k;
  int seed;
  logic [31:0] r;
  logic [7:0] v, pwr;
  logic [3:0] n1, n2;
  logic [7:0] rst_idx[9] = '{8'h07, 8'h20, 8'h21, 8'h22, 8'h23,
                             8'h24, 8'h26, 8'h27, 8'h02};
  logic [7:0] rst_val[9] = '{8'h00, 8'hA5, 8'h01, 8'h00, 8'h00,
                             8'h44, 8'h2E, 8'h00, 8'h00};
  logic [7:0] rsv_idx[11] = '{8'h00, 8'h01, 8'h03, 8'h06, 8'h08, 8'h18,
                              8'h1A, 8'h1F, 8'h25, 8'h28, 8'h2F};
  logic [15:0] straps[4] = '{16'h162E, 16'h164E, 16'h002E, 16'h004E};

  cgr_host i_cgr_host (.clk_in(clk_in), .cfg_mode_out(cfg_mode),
    .io_addr_out(io_addr), .io_wr_out(io_wr), .io_rd_out(io_rd),
    .io_wdata_out(io_wdata));

  cgr_bank i_cgr_bank (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .bus_rst_in(bus_rst_in), .standby_por_in(standby_por_in),
    .sysopt_in(sysopt_in), .cfg_mode_in(cfg_mode), .io_addr_in(io_addr),
    .io_wr_in(io_wr), .io_rd_in(io_rd), .io_wdata_in(io_wdata),
    .io_rdata_out(io_rdata_out), .io_rdata_valid_out(io_rdata_valid_out),
    .ldev_select_out(ldev_select_out), .ldev_active_out(ldev_active_out),
    .soft_reset_out(soft_reset_out), .floppy_ctrl_power_out(fpw),
    .par_port_power_out(ppw), .ser1_power_out(s1pw),
    .ser2_power_out(s2pw), .pll_off_out(pll_off),
    .osc_stop_out(osc_stop), .baud_rate_clock_en_out(brg_en),
    .addr16_qual_out(q16), .cfg_base_out(cfg_base_out));

  // 100 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Mismatch report
  task automatic miss(input string msg);
    error_cnt++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask

  // Read data compare
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) miss($sformatf("read %h want %h", got, exp));
  endtask

  // Output level compare
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    compares++;
    if (got !== exp) miss($sformatf("%s %h want %h", msg, got, exp));
  endtask

  // Counts and verdict
  task automatic test_done;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read answers matched against the oldest noted expectation
  always @(negedge clk_in) begin
    if (io_rdata_valid_out === 1'b1) begin
      if (i_cgr_host.exp_q.size() == 0) miss("unexpected read answer");
      else chk8(io_rdata_out, i_cgr_host.exp_q.pop_front());
    end
  end

  // Hang guard, well beyond the few hundred cycles needed
  initial begin
    #200000;
    miss("timeout");
    test_done();
  end

  // Main sequence
  initial begin
    seed = 32'h06ad;
    error_cnt = 0;
    compares = 0;
    rst_b_in = 1'b0;
    bus_rst_in = 1'b0;
    standby_por_in = 1'b0;
    sysopt_in = 2'b10;
    repeat (8) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk16(cfg_base_out, 16'h002E, "strap base");
    for (k = 0; k < 9; k++)
      i_cgr_host.rreg(rst_idx[k], rst_val[k]);
    // Reserved places drop random writes
    for (k = 0; k < 11; k++) begin
      r = $random(seed);
      i_cgr_host.wreg(rsv_idx[k], r[7:0]);
      i_cgr_host.rreg(rsv_idx[k], 8'h00);
    end
    // Power enables, floppy forced on for the soft reset later
    r = $random(seed);
    v = r[7:0] | 8'h01;
    pwr = v & 8'h39;
    i_cgr_host.wreg(8'h22, v);
    i_cgr_host.idle();
    chk16({s2pw, s1pw, ppw, fpw}, {pwr[5], pwr[4], pwr[3], pwr[0]},
          "power");
    i_cgr_host.rreg(8'h22, pwr);
    // Every PLL and clock code, reserved bits set too
    for (k = 0; k < 8; k++) begin
      v = {2'b11, 2'b11, k[2:1], k[0], 1'b1};
      i_cgr_host.wreg(8'h24, v);
      i_cgr_host.idle();
      @(negedge clk_in);
      chk16({pll_off, osc_stop, brg_en, q16}, {k[0], k[2:1] == 2'b11,
            k[2:1] != 2'b11, 1'b1}, "osc");
      i_cgr_host.rreg(8'h24, v & 8'h4E);
    end
    // 12-bit qualification lets an upper alias hit
    i_cgr_host.wreg(8'h24, 8'h00);
    i_cgr_host.acc(1'b1, i_cgr_host.base | 16'hF000, 8'h22, 1'b1);
    i_cgr_host.acc(1'b0, i_cgr_host.base | 16'hF001, pwr, 1'b1);
    // Recommended 16-bit setting; the alias must now be ignored
    i_cgr_host.wreg(8'h24, 8'h40);
    i_cgr_host.acc(1'b1, i_cgr_host.base | 16'hF000, 8'h24, 1'b1);
    i_cgr_host.acc(1'b0, i_cgr_host.base | 16'hF001, 8'h00, 1'b0);
    i_cgr_host.rreg(8'h22, pwr);
    // Upper index bit must not alias onto power control
    i_cgr_host.wreg(8'hA2, 8'h00);
    i_cgr_host.rreg(8'h22, pwr);
    i_cgr_host.rreg(8'hA2, 8'h00);
    // Outside configuration mode nothing is reached
    i_cgr_host.idle();
    i_cgr_host.cfg_mode_out = 1'b0;
    i_cgr_host.wreg(8'h22, 8'h00);
    i_cgr_host.acc(1'b0, i_cgr_host.base + 16'h0001, 8'h00, 1'b0);
    i_cgr_host.idle();
    i_cgr_host.cfg_mode_out = 1'b1;
    i_cgr_host.rreg(8'h22, pwr);
    // Activate reaches only the selected device
    r = $random(seed);
    n1 = r[3:0];
    n2 = n1 ^ 4'h5;
    i_cgr_host.wreg(8'h07, {4'h0, n1});
    i_cgr_host.wreg(8'h30, 8'h01);
    i_cgr_host.wreg(8'h07, {4'h0, n2});
    i_cgr_host.wreg(8'h30, 8'h01);
    i_cgr_host.idle();
    chk16(ldev_active_out, (16'h1 << n1) | (16'h1 << n2), "act");
    chk16({8'h00, ldev_select_out}, {12'h000, n2}, "sel");
    i_cgr_host.wreg(8'h07, {4'h0, n1});
    i_cgr_host.wreg(8'h30, 8'h00);
    i_cgr_host.wreg(8'h07, 8'h20);
    i_cgr_host.wreg(8'h30, 8'h01);
    i_cgr_host.idle();
    chk16(ldev_active_out, 16'h1 << n2, "act");
    i_cgr_host.wreg(8'h07, {4'h0, n2});
    i_cgr_host.rreg(8'h30, 8'h01);
    // Soft reset pulse and what it clears
    i_cgr_host.wreg(8'h02, 8'h01);
    i_cgr_host.idle();
    chk16({15'h0, soft_reset_out}, 16'h0001, "soft");
    @(negedge clk_in);
    chk16({ldev_active_out[14:0], soft_reset_out}, 16'h0000, "soft");
    chk16({ldev_select_out, fpw, ppw, s1pw, s2pw}, 12'h000, "clr");
    i_cgr_host.rreg(8'h24, 8'h40);
    i_cgr_host.rreg(8'h02, 8'h00);
    // Port moves only when byte 1 lands
    i_cgr_host.wreg(8'h26, 8'h4F);
    i_cgr_host.idle();
    chk16(cfg_base_out, 16'h002E, "early move");
    i_cgr_host.wreg(8'h27, 8'h16);
    i_cgr_host.base = 16'h164E;
    i_cgr_host.idle();
    chk16(cfg_base_out, 16'h164E, "moved");
    i_cgr_host.rreg(8'h26, 8'h4E);
    i_cgr_host.rreg(8'h27, 8'h16);
    // Soft and standby resets leave the port alone
    i_cgr_host.wreg(8'h02, 8'h01);
    i_cgr_host.idle();
    standby_por_in = 1'b1;
    @(negedge clk_in);
    standby_por_in = 1'b0;
    @(negedge clk_in);
    chk16(cfg_base_out, 16'h164E, "kept");
    i_cgr_host.rreg(8'h24, 8'h44);
    // Bus reset reloads the strap choice
    for (k = 0; k < 4; k++) begin
      i_cgr_host.idle();
      sysopt_in = k[1:0];
      bus_rst_in = 1'b1;
      @(negedge clk_in);
      bus_rst_in = 1'b0;
      @(negedge clk_in);
      chk16(cfg_base_out, straps[k], "bus strap");
      i_cgr_host.base = straps[k];
      i_cgr_host.rreg(8'h26, straps[k][7:0]);
    end
    // Main power-on in mid-run
    i_cgr_host.idle();
    rst_b_in = 1'b0;
    @(negedge clk_in);
    chk16(cfg_base_out, 16'h002E, "por base");
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk16(cfg_base_out, 16'h004E, "por strap");
    repeat (3) @(negedge clk_in);
    if (i_cgr_host.exp_q.size() != 0) miss("read answers missing");
    test_done();
  end
endmodule
`default_nettype wire
